// *** hdl/nbt_bar_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module nbt_bar_regs (
  // Clock and power-up reset
  input wire logic clk,
  input wire logic reset_n,
  // Hot or fundamental link reset, from a pin
  input wire logic link_reset_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Translation request
  input wire logic xl_req_valid,
  input wire logic [1:0] xl_req_bar,
  input wire logic [63:0] xl_req_addr,
  // Translation answer
  output logic xl_rsp_valid,
  output logic xl_rsp_hit,
  output logic [63:0] xl_rsp_addr,
  // BAR state
  output logic [2:0] bar_enabled
);

  localparam int NBAR = 3;

  // Setup and translation state, power-up reset only
  nbt_pkg::nbt_word_t setup_q [NBAR];
  nbt_pkg::nbt_word_t setup_d [NBAR];
  nbt_pkg::nbt_word_t tbase0_q, tbase0_d;
  nbt_pkg::nbt_word_t tbase1_q, tbase1_d;

  // BAR base registers, also cleared by link reset
  nbt_pkg::nbt_word_t base_q [NBAR];
  nbt_pkg::nbt_word_t base_d [NBAR];

  // Link reset synchroniser
  logic lrst_meta_q;
  logic lrst_sync_q;

  // Read data and BAR state
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] enabled_q, enabled_d;

  // Decoded modes
  logic pair_mode;
  logic [NBAR-1:0] active;
  nbt_pkg::nbt_xaddr_t mask [NBAR];
  nbt_pkg::nbt_word_t bar_rd [NBAR];

  nbt_xl_if xl ();

  // Link reset synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_meta_q <= 1'b0;
      lrst_sync_q <= 1'b0;
    end else begin
      lrst_meta_q <= link_reset_n;
      lrst_sync_q <= lrst_meta_q;
    end
  end

  // Mode decode
  always_comb begin
    pair_mode = nbt_pkg::nbt_is_64(setup_q[0]);
    for (int i = 0; i < NBAR; i++) begin
      active[i] = nbt_pkg::nbt_active(setup_q[i]);
      mask[i] = nbt_pkg::nbt_win_mask(nbt_pkg::nbt_size(setup_q[i]));
      if (!nbt_pkg::nbt_is_64(setup_q[i])) begin
        // 32-bit decoding stays in the lower 4 GB
        mask[i][63:32] = nbt_pkg::ALL_MASK;
      end
      if ((nbt_pkg::nbt_size(setup_q[i]) != nbt_pkg::SIZE_FULL) &&
          (nbt_pkg::nbt_size(setup_q[i]) < nbt_pkg::SIZE_MIN)) begin
        // Too small a size leaves no writable base bit
        mask[i] = '0;
      end
    end
    // BAR1 is the upper half of BAR0 when paired
    if (pair_mode) begin
      active[1] = active[0];
    end
  end

  // BAR read values
  always_comb begin
    for (int i = 0; i < NBAR; i++) begin
      bar_rd[i] = nbt_pkg::ZERO_WORD;
      if (active[i]) begin
        bar_rd[i] = (base_q[i] & mask[i][31:0]) | {28'h0, setup_q[i][nbt_pkg::ATTR_HI:0]};
      end
    end
    if (pair_mode) begin
      bar_rd[1] = nbt_pkg::ZERO_WORD;
      if (active[0]) begin
        bar_rd[1] = base_q[1] & mask[0][63:32];
      end
    end
  end

  // Setup and translation registers
  always_comb begin
    for (int i = 0; i < NBAR; i++) begin
      setup_d[i] = setup_q[i];
    end
    tbase0_d = tbase0_q;
    tbase1_d = tbase1_q;
    if (reg_wr) begin
      case (reg_addr)
        nbt_pkg::OFF_BAR0_SETUP: begin
          setup_d[0] = nbt_pkg::nbt_setup_clean(reg_wdata);
        end
        nbt_pkg::OFF_BAR1_SETUP: begin
          setup_d[1] = nbt_pkg::nbt_setup_clean(reg_wdata);
        end
        nbt_pkg::OFF_BAR2_SETUP: begin
          setup_d[2] = nbt_pkg::nbt_setup_clean(reg_wdata);
        end
        nbt_pkg::OFF_BAR0_TBASE: begin
          tbase0_d = reg_wdata & nbt_pkg::TBASE_MASK;
        end
        nbt_pkg::OFF_BAR1_TBASE: begin
          if (pair_mode) begin
            tbase1_d = reg_wdata & nbt_pkg::ALL_MASK;
          end else begin
            tbase1_d = reg_wdata & nbt_pkg::TBASE_MASK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Only power-up reset touches these
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NBAR; i++) begin
        setup_q[i] <= nbt_pkg::SETUP_RESET;
      end
      tbase0_q <= nbt_pkg::TBASE_RESET;
      tbase1_q <= nbt_pkg::TBASE_RESET;
    end else begin
      for (int i = 0; i < NBAR; i++) begin
        setup_q[i] <= setup_d[i];
      end
      tbase0_q <= tbase0_d;
      tbase1_q <= tbase1_d;
    end
  end

  // BAR base registers
  always_comb begin
    for (int i = 0; i < NBAR; i++) begin
      base_d[i] = base_q[i];
    end
    if (!lrst_sync_q) begin
      for (int i = 0; i < NBAR; i++) begin
        base_d[i] = nbt_pkg::BASE_RESET;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        nbt_pkg::OFF_BAR0: begin
          base_d[0] = reg_wdata & mask[0][31:0] & nbt_pkg::TBASE_MASK;
        end
        nbt_pkg::OFF_BAR1: begin
          if (pair_mode) begin
            base_d[1] = reg_wdata & mask[0][63:32];
          end else begin
            base_d[1] = reg_wdata & mask[1][31:0] & nbt_pkg::TBASE_MASK;
          end
        end
        nbt_pkg::OFF_BAR2: begin
          base_d[2] = reg_wdata & mask[2][31:0] & nbt_pkg::TBASE_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NBAR; i++) begin
        base_q[i] <= nbt_pkg::BASE_RESET;
      end
    end else begin
      for (int i = 0; i < NBAR; i++) begin
        base_q[i] <= base_d[i];
      end
    end
  end

  // Register read
  always_comb begin
    rdata_d = nbt_pkg::ZERO_WORD;
    if (reg_rd) begin
      case (reg_addr)
        nbt_pkg::OFF_BAR0: begin
          rdata_d = bar_rd[0];
        end
        nbt_pkg::OFF_BAR1: begin
          rdata_d = bar_rd[1];
        end
        nbt_pkg::OFF_BAR2: begin
          rdata_d = bar_rd[2];
        end
        nbt_pkg::OFF_BAR0_SETUP: begin
          rdata_d = setup_q[0];
        end
        nbt_pkg::OFF_BAR1_SETUP: begin
          rdata_d = setup_q[1];
        end
        nbt_pkg::OFF_BAR2_SETUP: begin
          rdata_d = setup_q[2];
        end
        nbt_pkg::OFF_BAR0_TBASE: begin
          rdata_d = tbase0_q & nbt_pkg::TBASE_MASK;
        end
        nbt_pkg::OFF_BAR1_TBASE: begin
          // Low bits appear only while paired
          rdata_d = pair_mode ? tbase1_q : (tbase1_q & nbt_pkg::TBASE_MASK);
        end
        default: begin
          rdata_d = nbt_pkg::ZERO_WORD;
        end
      endcase
    end
    enabled_d = active;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= nbt_pkg::ZERO_WORD;
      enabled_q <= 3'h0;
    end else begin
      rdata_q <= rdata_d;
      enabled_q <= enabled_d;
    end
  end

  // Window selection for the translation unit
  always_comb begin
    xl.req_valid = xl_req_valid;
    xl.req_addr = xl_req_addr;
    xl.win_on = 1'b0;
    xl.win_base = '0;
    xl.win_mask = '0;
    xl.xlat_base = '0;
    case (xl_req_bar)
      2'h0: begin
        xl.win_on = active[0] && !setup_q[0][nbt_pkg::SPACE_BIT];
        xl.win_mask = mask[0];
        if (pair_mode) begin
          xl.win_base = {base_q[1], base_q[0] & nbt_pkg::TBASE_MASK};
          xl.xlat_base = {tbase1_q, tbase0_q & nbt_pkg::TBASE_MASK};
        end else begin
          xl.win_base = {32'h0, base_q[0] & nbt_pkg::TBASE_MASK};
          xl.xlat_base = {32'h0, tbase0_q & nbt_pkg::TBASE_MASK};
        end
      end
      2'h1: begin
        // No window of its own while paired
        xl.win_on = active[1] && !pair_mode && !setup_q[1][nbt_pkg::SPACE_BIT];
        xl.win_mask = mask[1];
        xl.win_base = {32'h0, base_q[1] & nbt_pkg::TBASE_MASK};
        xl.xlat_base = {32'h0, tbase1_q & nbt_pkg::TBASE_MASK};
      end
      2'h2: begin
        // No translation register: address passes unchanged
        xl.win_on = active[2] && !setup_q[2][nbt_pkg::SPACE_BIT];
        xl.win_mask = mask[2];
        xl.win_base = {32'h0, base_q[2] & nbt_pkg::TBASE_MASK};
        xl.xlat_base = xl.win_base;
      end
      default: begin
        xl.win_on = 1'b0;
      end
    endcase
  end

  nbt_xl_unit u_xl (
    .clk(clk),
    .reset_n(reset_n),
    .xl(xl)
  );

  assign reg_rdata = rdata_q;
  assign xl_rsp_valid = xl.rsp_valid;
  assign xl_rsp_hit = xl.rsp_hit;
  assign xl_rsp_addr = xl.rsp_addr;
  assign bar_enabled = enabled_q;

endmodule
`default_nettype wire

// *** hdl/nbt_pkg.sv ***
// Contract
// - Enable bit clear disables BAR, reads zero
// - Setup and translation survive fundamental, hot resets
// - BAR0 64-bit memory pairs translated bases
// - Paired BAR1 translated base fully read/write
// - Bits 31:4 remap BAR1 transactions
// - BAR2 bit 0 selects memory or I/O
// - Width code 0 is 32-bit, 2 is 64-bit
// - Width field reports and picks decoding
// - I/O space forces width field zero
// - Bit 3 reports prefetchable BAR
// - Size one to three zeroes base bits
`default_nettype none
package nbt_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int XADDR_W = 64;

  // Register byte offsets
  localparam logic [11:0] OFF_BAR0 = 12'h010;
  localparam logic [11:0] OFF_BAR1 = 12'h014;
  localparam logic [11:0] OFF_BAR2 = 12'h018;
  localparam logic [11:0] OFF_BAR0_SETUP = 12'h07c;
  localparam logic [11:0] OFF_BAR0_TBASE = 12'h080;
  localparam logic [11:0] OFF_BAR1_SETUP = 12'h084;
  localparam logic [11:0] OFF_BAR1_TBASE = 12'h088;
  localparam logic [11:0] OFF_BAR2_SETUP = 12'h08c;

  // Setup register fields
  localparam int SPACE_BIT = 0;
  localparam int WIDTH_LO = 1;
  localparam int WIDTH_HI = 2;
  localparam int PREFETCHABLE_SELECT_BIT = 3;
  localparam int SIZE_LO = 4;
  localparam int SIZE_HI = 9;
  localparam int EN_BIT = 31;
  localparam int ATTR_HI = 3;
  localparam int BASE_LSB = 4;
  localparam int HALF_W = 32;

  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_64 = 2'h2;
  localparam logic [5:0] SIZE_FULL = 6'h00;
  localparam logic [5:0] SIZE_MIN = 6'h04;

  localparam logic [31:0] SETUP_MASK = 32'h8000_03ff;
  localparam logic [31:0] TBASE_MASK = 32'hffff_fff0;
  localparam logic [31:0] ALL_MASK = 32'hffff_ffff;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] TBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef logic [31:0] nbt_word_t;
  typedef logic [63:0] nbt_xaddr_t;

  function automatic logic [5:0] nbt_size(input nbt_word_t setup);
    return setup[SIZE_HI:SIZE_LO];
  endfunction

  // Memory space with 64-bit decoding
  function automatic logic nbt_is_64(input nbt_word_t setup);
    return !setup[SPACE_BIT] && (setup[WIDTH_HI:WIDTH_LO] == WIDTH_64);
  endfunction

  // Enabled and with a usable size
  function automatic logic nbt_active(input nbt_word_t setup);
    logic [5:0] sz;
    sz = nbt_size(setup);
    return setup[EN_BIT] && ((sz == SIZE_FULL) || (sz >= SIZE_MIN));
  endfunction

  // Address bits at or above the size, never below bit four
  function automatic nbt_xaddr_t nbt_win_mask(input logic [5:0] sz);
    nbt_xaddr_t m;
    m = '0;
    for (int i = BASE_LSB; i < XADDR_W; i++) begin
      m[i] = (sz == SIZE_FULL) || (i >= int'(sz));
    end
    return m;
  endfunction

  // Setup value as stored after a write
  function automatic nbt_word_t nbt_setup_clean(input nbt_word_t wdata);
    nbt_word_t d;
    d = wdata & SETUP_MASK;
    if (d[SPACE_BIT]) begin
      d[WIDTH_HI:WIDTH_LO] = WIDTH_32;
    end
    return d;
  endfunction

endpackage
`default_nettype wire

// *** hdl/nbt_xl_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface nbt_xl_if;
  logic req_valid;
  logic [63:0] req_addr;
  logic win_on;
  logic [63:0] win_base;
  logic [63:0] win_mask;
  logic [63:0] xlat_base;
  logic rsp_valid;
  logic rsp_hit;
  logic [63:0] rsp_addr;

  modport main (
    output req_valid,
    output req_addr,
    output win_on,
    output win_base,
    output win_mask,
    output xlat_base,
    input rsp_valid,
    input rsp_hit,
    input rsp_addr
  );

  modport unit (
    input req_valid,
    input req_addr,
    input win_on,
    input win_base,
    input win_mask,
    input xlat_base,
    output rsp_valid,
    output rsp_hit,
    output rsp_addr
  );
endinterface
`default_nettype wire

// *** hdl/nbt_xl_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
module nbt_xl_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Window and request
  nbt_xl_if.unit xl
);

  logic valid_q, valid_d;
  logic hit_q, hit_d;
  logic [63:0] addr_q, addr_d;

  always_comb begin
    valid_d = xl.req_valid;
    hit_d = xl.req_valid && xl.win_on && (((xl.req_addr ^ xl.win_base) & xl.win_mask) == '0);
    addr_d = xl.req_addr;
    if (hit_d) begin
      // Keep the offset, replace the window bits
      addr_d = (xl.req_addr & ~xl.win_mask) | (xl.xlat_base & xl.win_mask);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      hit_q <= 1'b0;
      addr_q <= '0;
    end else begin
      valid_q <= valid_d;
      hit_q <= hit_d;
      addr_q <= addr_d;
    end
  end

  assign xl.rsp_valid = valid_q;
  assign xl.rsp_hit = hit_q;
  assign xl.rsp_addr = addr_q;

endmodule
`default_nettype wire

// *** verif/nbt_bar_regs_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module nbt_bar_regs_chk (
  // Clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_reset_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Translation
  input wire logic xl_req_valid,
  input wire logic [1:0] xl_req_bar,
  input wire logic [63:0] xl_req_addr,
  input wire logic xl_rsp_valid,
  input wire logic xl_rsp_hit,
  input wire logic [63:0] xl_rsp_addr,
  input wire logic [2:0] bar_enabled
);
  logic [31:0] s2_q;
  logic [31:0] s2_d;
  logic act2;
  logic rd_b2;
  logic rd_s2;
  logic [31:0] s0_q;
  logic [31:0] s0_d;
  logic act0;
  logic pair0;

  // Shadows of the BAR 2 and BAR 0 setup words
  always_comb begin
    s2_d = s2_q;
    s0_d = s0_q;
    if (reg_wr && reg_addr == 12'h08c) begin
      s2_d = reg_wdata & 32'h8000_03ff;
      if (reg_wdata[0]) begin
        s2_d[2:1] = 2'h0;
      end
    end
    if (reg_wr && reg_addr == 12'h07c) begin
      s0_d = reg_wdata & 32'h8000_03ff;
      if (reg_wdata[0]) begin
        s0_d[2:1] = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s2_q <= 32'h0000_0000;
      s0_q <= 32'h0000_0000;
    end else begin
      s2_q <= s2_d;
      s0_q <= s0_d;
    end
  end

  assign act2 = s2_q[31] && (s2_q[9:4] == 6'h00 || s2_q[9:4] >= 6'h04);
  assign act0 = s0_q[31] && (s0_q[9:4] == 6'h00 || s0_q[9:4] >= 6'h04);
  assign pair0 = !s0_q[0] && (s0_q[2:1] == 2'h2);
  assign rd_b2 = reg_rd && reg_addr == 12'h018;
  assign rd_s2 = reg_rd && reg_addr == 12'h08c;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  setup_keep_a: assert property (rd_s2 |=> reg_rdata == s2_q)
    else $error("setup word lost");
  io_width_a: assert property (rd_s2 ##1 reg_rdata[0] |-> reg_rdata[2:1] == 2'h0)
    else $error("io space with nonzero width");
  setup_rsvd_a: assert property (rd_s2 |=> (reg_rdata & 32'h7fff_fc00) == 32'h0000_0000)
    else $error("setup reserved bits set");
  bar_off_a: assert property (rd_b2 && !s2_q[31] |=> reg_rdata == 32'h0000_0000)
    else $error("disabled bar reads nonzero");
  small_size_a: assert property (rd_b2 && s2_q[9:4] inside {6'h01, 6'h02, 6'h03} |=> reg_rdata == 32'h0000_0000)
    else $error("small size bar reads nonzero");
  bar_attr_a: assert property (rd_b2 && act2 |=> reg_rdata[3:0] == s2_q[3:0])
    else $error("bar attributes differ from setup");
  tbase_rsvd_a: assert property (reg_rd && reg_addr == 12'h080 |=> reg_rdata[3:0] == 4'h0)
    else $error("translated base low bits set");
  xl_answer_a: assert property (xl_rsp_valid == $past(xl_req_valid))
    else $error("translation answer timing wrong");
  miss_pass_a: assert property (xl_req_valid |=> !xl_rsp_hit |-> xl_rsp_addr == $past(xl_req_addr))
    else $error("missed address altered");
  bar2_state_a: assert property (bar_enabled[2] == $past(act2))
    else $error("bar 2 enable state wrong");
  bar0_state_a: assert property (bar_enabled[0] == $past(act0))
    else $error("bar 0 enable state wrong");
  pair_follow_a: assert property ($past(pair0) |-> bar_enabled[1] == bar_enabled[0])
    else $error("paired bar 1 state differs from bar 0");

  cover property (rd_b2 && act2);
  cover property (xl_rsp_valid && xl_rsp_hit);
  cover property ($fell(link_reset_n));
  cover property (pair0 && xl_rsp_valid && xl_rsp_hit);
endmodule

bind nbt_bar_regs nbt_bar_regs_chk nbt_bar_regs_chk_inst (.clk(clk), .reset_n(reset_n),
  .link_reset_n(link_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xl_req_valid(xl_req_valid), .xl_req_bar(xl_req_bar),
  .xl_req_addr(xl_req_addr), .xl_rsp_valid(xl_rsp_valid), .xl_rsp_hit(xl_rsp_hit),
  .xl_rsp_addr(xl_rsp_addr), .bar_enabled(bar_enabled));
`default_nettype wire

// *** verif/test_bridge_bar_setup_translation.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, ex, got) \
  checks++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("BAD %s exp %h got %h", n, ex, got); \
  end
module test_bridge_bar_setup_translation;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic link_reset_n = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic xl_req_valid = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [1:0] xl_req_bar = 2'h0;
  logic [63:0] xl_req_addr = 64'h0;
  logic [31:0] reg_rdata, e, r, d, ew;
  logic [63:0] xl_rsp_addr;
  logic [64:0] x;
  logic xl_rsp_valid, xl_rsp_hit;
  logic [2:0] bar_enabled;
  logic [31:0] rq[$];
  logic [64:0] xq[$];
  int n_fail = 0;
  int checks = 0;

  always #50 clk = ~clk;

  nbt_bar_regs nbt_bar_regs_inst (.clk(clk), .reset_n(reset_n), .link_reset_n(link_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xl_req_valid(xl_req_valid), .xl_req_bar(xl_req_bar), .xl_req_addr(xl_req_addr),
    .xl_rsp_valid(xl_rsp_valid), .xl_rsp_hit(xl_rsp_hit), .xl_rsp_addr(xl_rsp_addr),
    .bar_enabled(bar_enabled));

  // On a read the data word is the expected answer
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] dv);
    xl_req_valid <= 1'b0;
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= dv;
    if (!w) begin
      rq.push_back(dv);
    end
    @(posedge clk);
  endtask

  task automatic xl(input logic [1:0] b, input logic [63:0] a, input logic h, input logic [63:0] ex);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    xl_req_valid <= 1'b1;
    xl_req_bar <= b;
    xl_req_addr <= a;
    xq.push_back({h, ex});
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    xl_req_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (rd_d) begin
      ew = rq.pop_front();
      `CHK("rdata", ew, reg_rdata)
    end
    if (xl_rsp_valid === 1'b1) begin
      x = xq.pop_front();
      `CHK("hit", x[64], xl_rsp_hit)
      `CHK("xaddr", x[63:0], xl_rsp_addr)
    end
    rd_d <= reg_rd;
  end

  initial begin
    repeat (400) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial begin
    r = $urandom(20);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(0, 12'h08c, 32'h0000_0000);
    acc(0, 12'h088, 32'h0000_0000);
    acc(1, 12'h08c, 32'hffff_ffff);
    acc(0, 12'h08c, 32'h8000_03f9);
    for (int c = 0; c < 8; c++) begin
      r = $urandom;
      d = {1'b1, 21'h0, 6'h00, r[3], c[1:0], c[2]};
      e = d;
      if (c[2]) begin
        e[2:1] = 2'h0;
      end
      acc(1, 12'h08c, d);
      acc(0, 12'h08c, e);
      acc(0, 12'h018, {28'h0, e[3:0]});
    end
    acc(1, 12'h08c, 32'h0000_0008);
    acc(0, 12'h018, 32'h0000_0000);
    for (int s = 1; s < 4; s++) begin
      acc(1, 12'h08c, {1'b1, 21'h0, s[5:0], 4'h0});
      acc(1, 12'h018, 32'hffff_fff0);
      acc(0, 12'h018, 32'h0000_0000);
    end
    r = $urandom;
    acc(1, 12'h08c, 32'h8000_0080);
    acc(0, 12'h018, 32'h0000_0000);
    acc(1, 12'h018, r);
    acc(0, 12'h018, {r[31:8], 8'h00});
    xl(2'h2, {32'h0, r[31:8], 8'h5a}, 1'b1, {32'h0, r[31:8], 8'h5a});
    xl(2'h3, 64'h0000_0000_0000_005a, 1'b0, 64'h0000_0000_0000_005a);
    acc(1, 12'h100, r);
    acc(0, 12'h100, 32'h0000_0000);
    acc(0, 12'h08c, 32'h8000_0080);
    acc(1, 12'h088, 32'hffff_ffff);
    acc(0, 12'h088, 32'hffff_fff0);
    acc(1, 12'h07c, 32'h8000_00c4);
    acc(1, 12'h088, 32'h1234_5677);
    acc(0, 12'h088, 32'h1234_5677);
    acc(1, 12'h010, 32'h0000_5000);
    acc(1, 12'h014, 32'h0000_0001);
    acc(1, 12'h080, 32'habcd_e000);
    acc(0, 12'h010, 32'h0000_5004);
    acc(0, 12'h014, 32'h0000_0001);
    r = $urandom;
    xl(2'h0, {32'h1, 20'h00005, r[11:0]}, 1'b1, {32'h1234_5677, 20'habcde, r[11:0]});
    xl(2'h0, 64'h0000_0001_0000_6abc, 1'b0, 64'h0000_0001_0000_6abc);
    xl(2'h1, 64'h0000_0001_0000_5abc, 1'b0, 64'h0000_0001_0000_5abc);
    acc(1, 12'h07c, 32'h0000_0000);
    acc(1, 12'h084, 32'h8000_0100);
    acc(1, 12'h014, 32'h0003_0000);
    acc(1, 12'h088, 32'h7777_000f);
    acc(0, 12'h088, 32'h7777_0000);
    xl(2'h1, 64'h0000_0000_0003_1234, 1'b1, 64'h0000_0000_7777_1234);
    xl(2'h1, 64'h0000_0001_0003_1234, 1'b0, 64'h0000_0001_0003_1234);
    idle(2);
    link_reset_n <= 1'b0;
    idle(5);
    link_reset_n <= 1'b1;
    idle(4);
    acc(0, 12'h08c, 32'h8000_0080);
    acc(0, 12'h088, 32'h7777_0000);
    acc(0, 12'h084, 32'h8000_0100);
    acc(0, 12'h014, 32'h0000_0000);
    xl(2'h1, 64'h0000_0000_0000_1234, 1'b1, 64'h0000_0000_7777_1234);
    idle(3);
    finish_test;
  end
endmodule
`default_nettype wire
